//--- rtl/wcd_pkg.sv
package wcd_pkg;
  localparam int unsigned INSTR_W  = 16;
  localparam int unsigned COND_W   = 6;
  localparam int unsigned OFF_W    = 5;
  localparam int unsigned ROW_W    = 3;
  localparam int unsigned NUM_ROWS = 5;
  localparam int unsigned ROUTE_W  = 2;
  localparam int unsigned NUM_FLAG = 16;
  localparam int unsigned NUM_TC   = 4;
  localparam int unsigned NUM_SC   = 3;
  localparam int unsigned NUM_CUR  = 6;
  localparam int unsigned NUM_COND = 64;
  // Wait-entry relative word layout
  localparam int unsigned WE_OP_HI   = 15;
  localparam int unsigned WE_OP_LO   = 14;
  localparam int unsigned WE_OFF_HI  = 13;
  localparam int unsigned WE_OFF_LO  = 9;
  localparam int unsigned WE_ROW_HI  = 8;
  localparam int unsigned WE_ROW_LO  = 6;
  localparam int unsigned WE_COND_HI = 5;
  localparam int unsigned WE_COND_LO = 0;
  localparam logic [1:0]  WE_OPCODE  = 2'h3;
  localparam logic [2:0]  LAST_ROW   = 3'h4;
  // Current route word layout
  localparam int unsigned CR_OP_HI   = 15;
  localparam int unsigned CR_OP_LO   = 2;
  localparam int unsigned CR_SEL_HI  = 1;
  localparam logic [13:0] CR_OPCODE  = 14'h0D5E;
  // Condition code bases
  localparam logic [5:0] COND_FLAG_LOW   = 6'h00;
  localparam logic [5:0] COND_FLAG_HIGH  = 6'h10;
  localparam logic [5:0] COND_TC         = 6'h20;
  localparam logic [5:0] COND_START_LOW  = 6'h24;
  localparam logic [5:0] COND_START_HIGH = 6'h25;
  localparam logic [5:0] COND_VDS_LOW    = 6'h26;
  localparam logic [5:0] COND_SRC_LOW    = 6'h29;
  localparam logic [5:0] COND_VDS_HIGH   = 6'h2C;
  localparam logic [5:0] COND_ALU_DONE   = 6'h2F;
  localparam logic [5:0] COND_BOOST_HIGH = 6'h30;
  localparam logic [5:0] COND_BOOST_LOW  = 6'h31;
  localparam logic [5:0] COND_CUR_HIGH   = 6'h32;
  localparam logic [5:0] COND_CUR_LOW    = 6'h38;
  localparam logic [5:0] COND_OWN_HIGH   = 6'h3E;
  localparam logic [5:0] COND_OWN_LOW    = 6'h3F;
  // Synchronised pin vector layout
  localparam int unsigned SY_START = 0;
  localparam int unsigned SY_VDS   = 1;
  localparam int unsigned SY_SRC   = 4;
  localparam int unsigned SY_BOOST = 7;
  localparam int unsigned SY_CUR   = 8;
  localparam int unsigned SYNC_W   = 14;
  // APB map
  localparam int unsigned PADDR_W    = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_JUMP   = 8'h08;
  localparam int unsigned CTRL_WAIT  = 8;
  localparam int unsigned STAT_BAD   = 8;
  localparam int unsigned STAT_WAIT  = 9;
endpackage

//--- rtl/wcd_dec_if.sv
`timescale 1ns/1ps
interface wcd_dec_if;
  logic [wcd_pkg::INSTR_W-1:0] word;
  logic                        wait_entry;
  logic [wcd_pkg::OFF_W-1:0]   offset;
  logic [wcd_pkg::ROW_W-1:0]   row;
  logic                        row_ok;
  logic [wcd_pkg::COND_W-1:0]  cond;
  logic                        cur_route;
  logic [wcd_pkg::ROUTE_W-1:0] route;
  modport dec  (input word, output wait_entry, offset, row, row_ok, cond, cur_route, route);
  modport core (output word, input wait_entry, offset, row, row_ok, cond, cur_route, route);
endinterface

//--- rtl/wcd_decode.sv
`timescale 1ns/1ps
module wcd_decode (
  wcd_dec_if.dec d // Instruction word in, fields out
);
  always_comb begin
    d.wait_entry = d.word[wcd_pkg::WE_OP_HI:wcd_pkg::WE_OP_LO] == wcd_pkg::WE_OPCODE;
    d.offset     = d.word[wcd_pkg::WE_OFF_HI:wcd_pkg::WE_OFF_LO];
    d.row        = d.word[wcd_pkg::WE_ROW_HI:wcd_pkg::WE_ROW_LO];
    d.row_ok     = d.row <= wcd_pkg::LAST_ROW;
    d.cond       = d.word[wcd_pkg::WE_COND_HI:wcd_pkg::WE_COND_LO];
    d.cur_route  = d.word[wcd_pkg::CR_OP_HI:wcd_pkg::CR_OP_LO] == wcd_pkg::CR_OPCODE;
    d.route      = d.word[wcd_pkg::CR_SEL_HI:0];
  end
endmodule // wcd_decode

//--- rtl/wcd_cond_eval.sv
`timescale 1ns/1ps
module wcd_cond_eval (
  input  wire logic [wcd_pkg::COND_W-1:0]   code,   // Condition code of row
  input  wire logic [wcd_pkg::NUM_FLAG-1:0] flags,  // Internal flags
  input  wire logic [wcd_pkg::NUM_TC-1:0]   tc,     // Terminal counts
  input  wire logic                         start,  // Start input
  input  wire logic [wcd_pkg::NUM_SC-1:0]   vds,    // Drain-source feedback
  input  wire logic [wcd_pkg::NUM_SC-1:0]   src,    // Source feedback
  input  wire logic                         alu,    // Arithmetic op done
  input  wire logic                         boost,  // Boost voltage high
  input  wire logic [wcd_pkg::NUM_CUR-1:0]  cur,    // Current comparators
  input  wire logic [wcd_pkg::ROUTE_W-1:0]  route,  // Own current route
  output logic                              hit     // Condition true
);
  logic [wcd_pkg::NUM_COND-1:0] vec;
  always_comb begin
    vec = '0;
    vec[wcd_pkg::COND_FLAG_LOW +: wcd_pkg::NUM_FLAG] = ~flags;
    vec[wcd_pkg::COND_FLAG_HIGH +: wcd_pkg::NUM_FLAG] = flags;
    vec[wcd_pkg::COND_TC +: wcd_pkg::NUM_TC] = tc;
    vec[wcd_pkg::COND_START_LOW] = ~start;
    vec[wcd_pkg::COND_START_HIGH] = start;
    vec[wcd_pkg::COND_VDS_LOW +: wcd_pkg::NUM_SC] = ~vds;
    vec[wcd_pkg::COND_SRC_LOW +: wcd_pkg::NUM_SC] = ~src;
    vec[wcd_pkg::COND_VDS_HIGH +: wcd_pkg::NUM_SC] = vds;
    vec[wcd_pkg::COND_ALU_DONE] = alu;
    vec[wcd_pkg::COND_BOOST_HIGH] = boost;
    vec[wcd_pkg::COND_BOOST_LOW] = ~boost;
    vec[wcd_pkg::COND_CUR_HIGH +: wcd_pkg::NUM_CUR] = cur;
    vec[wcd_pkg::COND_CUR_LOW +: wcd_pkg::NUM_CUR] = ~cur;
    vec[wcd_pkg::COND_OWN_HIGH] = cur[route];
    vec[wcd_pkg::COND_OWN_LOW] = ~cur[route];
    hit = vec[code];
  end
endmodule // wcd_cond_eval

//--- rtl/wcd_top.sv
// Overview of operation
// - Offset is 5-bit signed, -16 to 15
// - Codes 0-31 test flags low, high
// - Terminal counts, start, shortcut feedback lows
// - Codes 44-46 test drain-source feedback high
// - Code 47 true when arithmetic op done
// - Boost high/low, current feedbacks high
// - Codes 56-61 test current feedbacks low
// - Codes 62-63 test routed own current
// - Row codes 0-4 select rows 1-5
// - Route instruction reroutes own current input
// - Selector picks measure block one..four low
// - Reset route depends on core and channel
// - Jump to entry address plus offset
// - Five rows, all evaluated together
`timescale 1ns/1ps
module wcd_top #(
  parameter int unsigned ADDR_W     = 10,  // Code address width
  parameter bit          CORE_ID    = 1'b0, // Core within channel
  parameter bit          CHANNEL_ID = 1'b0  // 0 for channel 1
) (
  input  wire logic                                pclk,        // Clock
  input  wire logic                                presetn,     // Async reset, low
  input  wire logic [wcd_pkg::PADDR_W-1:0]         paddr,       // APB address
  input  wire logic                                psel,        // APB select
  input  wire logic                                penable,     // APB enable
  input  wire logic                                pwrite,      // APB direction
  input  wire logic [31:0]                         pwdata,      // APB write data
  output logic      [31:0]                         prdata,      // APB read data
  output logic                                     pready,      // APB ready
  output logic                                     pslverr,     // APB error
  input  wire logic                                instr_valid, // Instruction executes
  input  wire logic [wcd_pkg::INSTR_W-1:0]         instr_word,  // Code RAM word
  input  wire logic [ADDR_W-1:0]                   instr_addr,  // Code RAM address
  input  wire logic [wcd_pkg::NUM_FLAG-1:0]        flag_in,     // Core flags
  input  wire logic [wcd_pkg::NUM_TC-1:0]          tc_in,       // Terminal counts
  input  wire logic                                alu_done_in, // Arithmetic op done
  input  wire logic                                start_in,    // Start pin
  input  wire logic [wcd_pkg::NUM_SC-1:0]          vds_fb_in,   // Drain-source pins
  input  wire logic [wcd_pkg::NUM_SC-1:0]          src_fb_in,   // Source pins
  input  wire logic                                boost_in,    // Boost comparator
  input  wire logic [wcd_pkg::NUM_CUR-1:0]         cur_fb_in,   // Current comparators
  output logic      [wcd_pkg::ROUTE_W-1:0]         route_sel,   // Current route select
  output logic                                     wait_active, // Waiting on table
  output logic                                     jump_valid,  // Jump taken pulse
  output logic      [ADDR_W-1:0]                   jump_addr    // Jump destination
);
  localparam logic [wcd_pkg::ROUTE_W-1:0] DEF_ROUTE = {CHANNEL_ID, CORE_ID};

  // Jump adder needs room beyond the offset
  if (ADDR_W <= wcd_pkg::OFF_W || ADDR_W > 31) begin : g_addr_w_check
    $error("ADDR_W out of range");
  end

  typedef struct packed {
    logic [wcd_pkg::NUM_ROWS-1:0][wcd_pkg::COND_W-1:0] cond;
    logic [wcd_pkg::NUM_ROWS-1:0][wcd_pkg::OFF_W-1:0]  off;
    logic [wcd_pkg::NUM_ROWS-1:0][ADDR_W-1:0]          base;
    logic [wcd_pkg::NUM_ROWS-1:0]                      set;
    logic [wcd_pkg::NUM_ROWS-1:0]                      row_en;
    logic                                              wait_act;
    logic                                              bad_row;
    logic [wcd_pkg::ROUTE_W-1:0]                       route;
    logic                                              jump_valid;
    logic [ADDR_W-1:0]                                 jump_addr;
    logic                                              pready;
    logic                                              pslverr;
    logic [31:0]                                       prdata;
    logic [wcd_pkg::SYNC_W-1:0]                        sync1;
    logic [wcd_pkg::SYNC_W-1:0]                        sync2;
    logic                                              init;
  } wcd_state_t;

  wcd_state_t s_q;
  wcd_state_t s_d;
  wcd_dec_if  dec ();

  logic [wcd_pkg::NUM_ROWS-1:0]             hit;
  logic [wcd_pkg::NUM_ROWS-1:0]             fire;
  logic [wcd_pkg::NUM_ROWS-1:0][ADDR_W-1:0] tgt;

  assign dec.word = instr_word;

  wcd_decode u_decode (
    .d (dec.dec)
  );

  genvar g;
  generate
    for (g = 0; g < wcd_pkg::NUM_ROWS; g++) begin : g_row
      wcd_cond_eval u_eval (
        .code  (s_q.cond[g]),
        .flags (flag_in),
        .tc    (tc_in),
        .start (s_q.sync2[wcd_pkg::SY_START]),
        .vds   (s_q.sync2[wcd_pkg::SY_VDS +: wcd_pkg::NUM_SC]),
        .src   (s_q.sync2[wcd_pkg::SY_SRC +: wcd_pkg::NUM_SC]),
        .alu   (alu_done_in),
        .boost (s_q.sync2[wcd_pkg::SY_BOOST]),
        .cur   (s_q.sync2[wcd_pkg::SY_CUR +: wcd_pkg::NUM_CUR]),
        .route (s_q.route),
        .hit   (hit[g])
      );
      assign fire[g] = s_q.set[g] & s_q.row_en[g] & hit[g];
      // Entry address plus sign-extended offset
      assign tgt[g] = s_q.base[g]
                    + {{(ADDR_W - wcd_pkg::OFF_W){s_q.off[g][wcd_pkg::OFF_W-1]}}, s_q.off[g]};
    end
  endgenerate

  always_comb begin
    s_d            = s_q;
    s_d.sync1      = {cur_fb_in, boost_in, src_fb_in, vds_fb_in, start_in};
    s_d.sync2      = s_q.sync1;
    s_d.init       = 1'b0;
    s_d.jump_valid = 1'b0;
    s_d.pready     = 1'b0;
    s_d.pslverr    = 1'b0;
    // Read data captured one cycle into the access phase
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0;
      case (paddr)
        wcd_pkg::REG_CTRL: begin
          if (!pwrite) begin
            s_d.prdata[wcd_pkg::NUM_ROWS-1:0] = s_q.row_en;
            s_d.prdata[wcd_pkg::CTRL_WAIT]    = s_q.wait_act;
          end
        end
        wcd_pkg::REG_STATUS: begin
          if (!pwrite) begin
            s_d.prdata[wcd_pkg::ROUTE_W-1:0] = s_q.route;
            s_d.prdata[wcd_pkg::STAT_BAD]    = s_q.bad_row;
            s_d.prdata[wcd_pkg::STAT_WAIT]   = s_q.wait_act;
          end
        end
        wcd_pkg::REG_JUMP: begin
          if (!pwrite) begin
            s_d.prdata[ADDR_W-1:0] = s_q.jump_addr;
          end
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    // Lowest row wins when several hold at once
    if (s_q.wait_act && |fire) begin
      s_d.jump_valid = 1'b1;
      s_d.wait_act   = 1'b0;
      for (int i = wcd_pkg::NUM_ROWS - 1; i >= 0; i--) begin
        if (fire[i]) begin
          s_d.jump_addr = tgt[i];
        end
      end
    end
    // Writes take effect at the completing edge
    if (psel && penable && s_q.pready && pwrite) begin
      case (paddr)
        wcd_pkg::REG_CTRL: begin
          s_d.row_en   = pwdata[wcd_pkg::NUM_ROWS-1:0];
          s_d.wait_act = pwdata[wcd_pkg::CTRL_WAIT];
        end
        wcd_pkg::REG_STATUS: begin
          if (pwdata[wcd_pkg::STAT_BAD]) begin
            s_d.bad_row = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Decode after the clear so a new event wins
    if (instr_valid && dec.wait_entry) begin
      if (dec.row_ok) begin
        s_d.cond[dec.row] = dec.cond;
        s_d.off[dec.row]  = dec.offset;
        s_d.base[dec.row] = instr_addr;
        s_d.set[dec.row]  = 1'b1;
      end else begin
        s_d.bad_row = 1'b1;
      end
    end
    if (instr_valid && dec.cur_route) begin
      s_d.route = dec.route;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q       <= '0;
      s_q.route <= DEF_ROUTE;
      s_q.init  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign route_sel   = s_q.route;
  assign wait_active = s_q.wait_act;
  assign jump_valid  = s_q.jump_valid;
  assign jump_addr   = s_q.jump_addr;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_route_write;
    instr_valid && dec.cur_route |=> route_sel == $past(instr_word[wcd_pkg::CR_SEL_HI:0]);
  endproperty
  a_route_write: assert property (p_route_write) else $error("route not taken");

  property p_route_reset;
    s_q.init && !(instr_valid && dec.cur_route) |=> route_sel == DEF_ROUTE;
  endproperty
  a_route_reset: assert property (p_route_reset) else $error("bad reset route");

  property p_row_store;
    instr_valid && dec.wait_entry && dec.row_ok
      |=> s_q.cond[$past(dec.row)] == $past(instr_word[wcd_pkg::WE_COND_HI:wcd_pkg::WE_COND_LO])
          && s_q.set[$past(dec.row)];
  endproperty
  a_row_store: assert property (p_row_store) else $error("row not stored");

  property p_off_store;
    instr_valid && dec.wait_entry && dec.row_ok
      |=> s_q.off[$past(dec.row)] == $past(instr_word[wcd_pkg::WE_OFF_HI:wcd_pkg::WE_OFF_LO]);
  endproperty
  a_off_store: assert property (p_off_store) else $error("offset not stored");

  property p_bad_row;
    instr_valid && dec.wait_entry && !dec.row_ok |=> s_q.bad_row && $stable(s_q.set);
  endproperty
  a_bad_row: assert property (p_bad_row) else $error("undefined row accepted");

  property p_jump_cause;
    jump_valid |-> $past(s_q.wait_act) && $past(|fire);
  endproperty
  a_jump_cause: assert property (p_jump_cause) else $error("jump without cause");

  property p_jump_row0;
    s_q.wait_act && fire[0] |=> jump_valid && jump_addr == $past(tgt[0]);
  endproperty
  a_jump_row0: assert property (p_jump_row0) else $error("wrong jump target");

  property p_apb_pulse;
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready held");

  property p_wait_clear;
    s_q.wait_act && |fire && !(psel && penable && pready && pwrite && paddr == wcd_pkg::REG_CTRL)
      |=> !wait_active;
  endproperty
  a_wait_clear: assert property (p_wait_clear) else $error("wait not ended by jump");

  property p_wait_row_first_wins;
    s_q.wait_act && fire[1] && !fire[0] |=> jump_valid && jump_addr == $past(tgt[1]);
  endproperty
  a_wait_row_first_wins: assert property (p_wait_row_first_wins) else $error("wrong row priority");

  property p_no_jump;
    !s_q.wait_act |=> !jump_valid;
  endproperty
  a_no_jump: assert property (p_no_jump) else $error("jump while not waiting");

  property p_route_keep;
    !(instr_valid && dec.cur_route) |=> $stable(route_sel);
  endproperty
  a_route_keep: assert property (p_route_keep) else $error("route changed alone");

  property p_table_keep;
    !(instr_valid && dec.wait_entry)
      |=> $stable(s_q.cond) && $stable(s_q.off) && $stable(s_q.base) && $stable(s_q.set);
  endproperty
  a_table_keep: assert property (p_table_keep) else $error("table changed alone");

  property p_bad_keep;
    s_q.bad_row && !(psel && penable && pready && pwrite && paddr == wcd_pkg::REG_STATUS) |=> s_q.bad_row;
  endproperty
  a_bad_keep: assert property (p_bad_keep) else $error("row flag lost");

  property p_init_route;
    s_q.init |-> route_sel == DEF_ROUTE;
  endproperty
  a_init_route: assert property (p_init_route) else $error("reset route lost");

  property p_route_only;
    instr_valid && dec.cur_route |=> $stable(s_q.set);
  endproperty
  a_route_only: assert property (p_route_only) else $error("route word touched table");

  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");

  c_prio: cover property (s_q.wait_act && fire[0] && fire[2]);
  c_jump: cover property (jump_valid);
  c_route: cover property (instr_valid && dec.cur_route ##1 route_sel != DEF_ROUTE);
  c_bad: cover property ($rose(s_q.bad_row));
endmodule // wcd_top

//--- sim/wcd_top_tb.sv
`timescale 1ns/1ps
module wcd_top_tb;
  localparam int unsigned AW = 10;
  logic                              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                              instr_valid, alu_done_in, start_in, boost_in;
  logic                              wait_active, jump_valid;
  logic [wcd_pkg::PADDR_W-1:0]       paddr;
  logic [31:0]                       pwdata, prdata, r, r2;
  logic [wcd_pkg::INSTR_W-1:0]       instr_word;
  logic [AW-1:0]                     instr_addr, jump_addr, base;
  logic [wcd_pkg::NUM_FLAG-1:0]      flag_in;
  logic [wcd_pkg::NUM_TC-1:0]        tc_in;
  logic [wcd_pkg::NUM_SC-1:0]        vds_fb_in, src_fb_in;
  logic [wcd_pkg::NUM_CUR-1:0]       cur_fb_in;
  logic [wcd_pkg::ROUTE_W-1:0]       route_sel, exp_route, sel;
  logic [4:0]                        off;
  logic [5:0]                        code;
  logic [2:0]                        row;
  logic [32:0]                       e_rd;
  logic [AW-1:0]                     e_jmp;
  logic [32:0]                       exp_rd[$];
  logic [AW-1:0]                     exp_jmp[$];
  int                                fail_count, compares;

  wcd_top #(.ADDR_W(AW), .CORE_ID(1'b1), .CHANNEL_ID(1'b1)) i_wcd_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_addr(instr_addr), .flag_in(flag_in), .tc_in(tc_in),
    .alu_done_in(alu_done_in), .start_in(start_in), .vds_fb_in(vds_fb_in), .src_fb_in(src_fb_in),
    .boost_in(boost_in), .cur_fb_in(cur_fb_in), .route_sel(route_sel), .wait_active(wait_active),
    .jump_valid(jump_valid), .jump_addr(jump_addr));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [31:0] xorshift();
    r2 = r2 ^ (r2 << 13);
    r2 = r2 ^ (r2 >> 17);
    r2 = r2 ^ (r2 << 5);
    return r2;
  endfunction

  // Expected truth of a wait condition from the current inputs
  function automatic logic ref_cond(input logic [5:0] c);
    if (c[5:4] == 2'h0) return !flag_in[c[3:0]];
    if (c[5:4] == 2'h1) return flag_in[c[3:0]];
    if (c < 6'h24) return tc_in[c - 6'h20];
    if (c == 6'h24) return !start_in;
    if (c == 6'h25) return start_in;
    if (c < 6'h29) return !vds_fb_in[c - 6'h26];
    if (c < 6'h2C) return !src_fb_in[c - 6'h29];
    if (c < 6'h2F) return vds_fb_in[c - 6'h2C];
    if (c == 6'h2F) return alu_done_in;
    if (c == 6'h30) return boost_in;
    if (c == 6'h31) return !boost_in;
    if (c < 6'h38) return cur_fb_in[c - 6'h32];
    if (c < 6'h3E) return !cur_fb_in[c - 6'h38];
    return cur_fb_in[exp_route] ^ c[0];
  endfunction

  task automatic err(input string msg);
    fail_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) err(msg);
  endtask

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic timeout(input string msg);
    err(msg);
    print_verdict();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] ex);
    int n;
    exp_rd.push_back(ex);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout("apb answer missing");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ins(input logic [15:0] w, input logic [AW-1:0] a);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    instr_addr  <= a;
    @(posedge pclk);
    instr_valid <= 1'b0;
  endtask

  task automatic wait_jump();
    int n;
    n = 0;
    while (exp_jmp.size() != 0 && n < 30) begin
      @(posedge pclk);
      n++;
    end
    if (exp_jmp.size() != 0) timeout("jump missing");
  endtask

  // Result watchers: oldest note against each answer
  always @(posedge pclk) begin
    if (presetn === 1'b1 && pready === 1'b1) begin
      if (exp_rd.size() == 0) err("unexpected apb answer");
      else begin
        e_rd = exp_rd.pop_front();
        check({pslverr, prdata} === e_rd, "apb answer");
      end
    end
    if (presetn === 1'b1 && jump_valid === 1'b1) begin
      if (exp_jmp.size() == 0) err("unexpected jump");
      else begin
        e_jmp = exp_jmp.pop_front();
        check(jump_addr === e_jmp, "jump address");
      end
    end
  end

  initial begin
    repeat (100000) @(posedge pclk);
    timeout("run limit");
  end

  initial begin
    {psel, penable, pwrite, instr_valid, alu_done_in, start_in, boost_in} = '0;
    {paddr, pwdata, instr_word, instr_addr, flag_in, tc_in, vds_fb_in, src_fb_in, cur_fb_in} = '0;
    {fail_count, compares} = '0;
    r2 = 32'h0000_0015;
    exp_route = 2'h3;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0, 33'h0_0000_0003);
    $display("test reset done");
    for (int p = 0; p < 128; p++) begin
      r = xorshift();
      @(posedge pclk);
      {boost_in, src_fb_in, vds_fb_in, start_in, alu_done_in, tc_in, flag_in} <= r[28:0];
      r = xorshift();
      cur_fb_in <= r[5:0];
      off  = r[10:6];
      base = r[20:11];
      sel  = r[22:21];
      code = 6'(p);
      row  = 3'(p % 5);
      ins({14'h0D5E, sel}, base);
      exp_route = sel;
      apb(1'b0, 8'h04, 32'h0, {1'b0, 30'h0, sel});
      check(route_sel === sel, "route output");
      ins({2'h3, off, row, code}, base);
      if (ref_cond(code)) begin
        exp_jmp.push_back(base + {{5{off[4]}}, off});
        apb(1'b1, 8'h00, 32'h100 | (32'h1 << row), 33'h0);
        wait_jump();
        check(wait_active === 1'b0, "wait not cleared");
        apb(1'b0, 8'h08, 32'h0, {1'b0, 22'h0, base + {{5{off[4]}}, off}});
      end else begin
        apb(1'b1, 8'h00, 32'h100 | (32'h1 << row), 33'h0);
        repeat (8) @(posedge pclk);
        check(wait_active === 1'b1, "wait ended without cause");
        apb(1'b0, 8'h00, 32'h0, {1'b0, 32'h100 | (32'h1 << row)});
        apb(1'b1, 8'h00, 32'h0, 33'h0);
      end
    end
    $display("test conditions done");
    @(posedge pclk);
    alu_done_in <= 1'b1;
    ins({2'h3, 5'h03, 3'h0, 6'h2F}, 10'h064);
    ins({2'h3, 5'h07, 3'h2, 6'h2F}, 10'h064);
    exp_jmp.push_back(10'h067);
    apb(1'b1, 8'h00, 32'h105, 33'h0);
    wait_jump();
    apb(1'b1, 8'h08, 32'h3FF, 33'h0);
    apb(1'b0, 8'h08, 32'h0, 33'h0_0000_0067);
    apb(1'b0, 8'h00, 32'h0, 33'h0_0000_0005);
    $display("test row priority done");
    for (int k = 5; k < 8; k++) begin
      ins({2'h3, 5'h01, 3'(k), 6'h2F}, 10'h000);
      apb(1'b0, 8'h04, 32'h0, {1'b0, 32'h100 | 32'(exp_route)});
      apb(1'b1, 8'h04, 32'h100, 33'h0);
      apb(1'b0, 8'h04, 32'h0, {1'b0, 32'(exp_route)});
    end
    apb(1'b0, 8'h0C, 32'h0, 33'h1_0000_0000);
    $display("test undefined rows done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(route_sel === 2'h3 && wait_active === 1'b0 && jump_valid === 1'b0, "second reset");
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0, 33'h0_0000_0003);
    $display("test second reset done");
    print_verdict();
  end
endmodule // wcd_top_tb
